// File: hdl/eif_pkg.sv
// eif_pkg: constants and carriers for the two-channel external interrupt
// edge/noise filter block; shared by the top and the channel module.
package eif_pkg;

  // ----------------------------------------------------------------------
  // register map (printed offsets are not multiples of four: indices)
  // ----------------------------------------------------------------------
  localparam logic [11:0] EXT_IRQ2_CONFIG_IDX = 12'hFD9;
  localparam logic [11:0] EXT_IRQ3_CONFIG_IDX = 12'hFDA;
  localparam logic [13:0] EXT_IRQ2_CONFIG_ADDR = {EXT_IRQ2_CONFIG_IDX, 2'h0};
  localparam logic [13:0] EXT_IRQ3_CONFIG_ADDR = {EXT_IRQ3_CONFIG_IDX, 2'h0};
  localparam int          ADDR_W    = 14;
  localparam int          NUM_CHAN  = 2;

  // ----------------------------------------------------------------------
  // field layout of each config register
  // ----------------------------------------------------------------------
  localparam int RATE_LSB  = 0;
  localparam int EDGE_LSB  = 2;
  localparam int LEVEL_BIT = 4;
  localparam logic [7:0] CFG_RESET = 8'h00;

  typedef enum logic [1:0] {
    EDGE_RISE     = 2'h0,
    EDGE_FALL     = 2'h1,
    EDGE_BOTH     = 2'h2,
    EDGE_RESERVED = 2'h3
  } eif_edge_e;

  // ----------------------------------------------------------------------
  // sampling dividers
  // ----------------------------------------------------------------------
  localparam logic [3:0] DIV_MASK_1  = 4'h0;
  localparam logic [3:0] DIV_MASK_4  = 4'h3;
  localparam logic [3:0] DIV_MASK_8  = 4'h7;
  localparam logic [3:0] DIV_MASK_16 = 4'hF;
  localparam logic [1:0] SLOW_DIV_MASK = 2'h3;  // low_freq_clock / 4
  // samples that must agree before the filtered level moves
  localparam logic [1:0] FILTER_AGREE = 2'h2;

  typedef struct packed {
    eif_edge_e  edgeSel;
    logic [1:0] rate;
  } eif_cfg_s;

  typedef struct packed {
    logic       request;
    logic       level;
  } eif_evt_s;

endpackage : eif_pkg

// File: hdl/eif_channel.sv
// eif_channel: one channel: pin synchroniser, noise filter, edge detect.
// assumes pin is asynchronous, sample enables are one-cycle pulses on clock.
`timescale 1ns/10ps
module eif_channel
  import eif_pkg::*;
(
  // clock and reset
  input  wire logic     clock,
  input  wire logic     rst_n,
  input  wire logic     clockGate,
  // sampling
  input  wire logic     sampleEn,
  input  wire eif_cfg_s cfg,
  // pin and event
  input  wire logic     pinIn,
  output eif_evt_s      evt
);

  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       filtered;
    logic       prevFiltered;
    logic [1:0] agree;
    eif_evt_s   evt;
  } eif_ch_state_s;

  eif_ch_state_s st_reg;
  eif_ch_state_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.sync1 = pinIn;
    st_next.sync2 = st_reg.sync1;
    st_next.evt.request = 1'b0;
    if (!clockGate) begin
      // clock to the channel stopped: filter state is lost
      st_next.filtered     = 1'b0;
      st_next.prevFiltered = 1'b0;
      st_next.agree        = 2'h0;
    end else if (sampleEn) begin
      // pulse must persist FILTER_AGREE samples to be accepted
      if (st_reg.sync2 == st_reg.filtered) begin
        st_next.agree = 2'h0;
      end else if (st_reg.agree + 2'h1 >= FILTER_AGREE) begin
        st_next.filtered = st_reg.sync2;
        st_next.agree    = 2'h0;
      end else begin
        st_next.agree = st_reg.agree + 2'h1;
      end
      // compare consecutive filtered samples
      st_next.prevFiltered = st_reg.filtered;
      unique case (cfg.edgeSel)
        EDGE_RISE: st_next.evt.request =
          st_reg.filtered & ~st_reg.prevFiltered;
        EDGE_FALL: st_next.evt.request =
          ~st_reg.filtered & st_reg.prevFiltered;
        EDGE_BOTH: st_next.evt.request =
          st_reg.filtered ^ st_reg.prevFiltered;
        default:   st_next.evt.request = 1'b0;  // reserved code
      endcase
      if (st_next.evt.request) begin
        st_next.evt.level = st_reg.filtered;
      end
    end
    if (!clockGate) begin
      st_next.evt = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign evt = st_reg.evt;

endmodule : eif_channel

// File: hdl/eif_top.sv
// eif_top: APB slave with two channel config registers, sample dividers
// and two channel filters. assumes APB master on clock; pins asynchronous.
`timescale 1ns/10ps
module eif_top
  import eif_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // operating context
  input  wire logic              lowSpeedMode,
  input  wire logic              lowFreqClockTick,
  input  wire logic [1:0]        ext_irq_clock_gate,
  // pins and requests
  input  wire logic              ext_pin_channel_two,
  input  wire logic              ext_pin_channel_three,
  output logic      [1:0]        irqRequest
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    eif_cfg_s [NUM_CHAN-1:0] cfg;
    logic     [3:0]          gearDiv;
    logic     [1:0]          slowDiv;
    logic     [1:0]          tickSync;
    logic     [1:0]          gateSync1;
    logic     [1:0]          gateSync2;
    logic                    slowSync1;
    logic                    slowSync2;
    logic                    tickPrev;
    logic     [31:0]         prdata;
    logic                    pready;
    logic                    pslverr;
    logic     [1:0]          irq;
  } eif_state_s;

  eif_state_s st_reg;
  eif_state_s st_next;
  eif_evt_s   chEvt [NUM_CHAN];
  logic       sampleEn [NUM_CHAN];
  logic       pins [NUM_CHAN];
  logic       slowTick;

  assign pins[0] = ext_pin_channel_two;
  assign pins[1] = ext_pin_channel_three;
  assign slowTick = st_reg.tickSync[1] & ~st_reg.tickPrev;

  // ----------------------------------------------------------------------
  // decoding used for reads, writes and sample enables
  // ----------------------------------------------------------------------
  function automatic logic [1:0] decode_chan(input logic [ADDR_W-1:0] a);
    decode_chan = 2'h0;
    if (a == EXT_IRQ2_CONFIG_ADDR) begin
      decode_chan = 2'h1;
    end else if (a == EXT_IRQ3_CONFIG_ADDR) begin
      decode_chan = 2'h2;
    end
  endfunction : decode_chan

  function automatic logic [3:0] rate_mask(input logic [1:0] r);
    unique case (r)
      2'h0: rate_mask = DIV_MASK_1;
      2'h1: rate_mask = DIV_MASK_4;
      2'h2: rate_mask = DIV_MASK_8;
      2'h3: rate_mask = DIV_MASK_16;
    endcase
  endfunction : rate_mask

  // ----------------------------------------------------------------------
  // combinational next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [1:0] hit;
    hit = decode_chan(paddr);
    st_next = st_reg;
    st_next.tickSync  = {st_reg.tickSync[0], lowFreqClockTick};
    st_next.tickPrev  = st_reg.tickSync[1];
    st_next.gateSync1 = ext_irq_clock_gate;
    st_next.gateSync2 = st_reg.gateSync1;
    st_next.slowSync1 = lowSpeedMode;
    st_next.slowSync2 = st_reg.slowSync1;
    st_next.gearDiv   = st_reg.gearDiv + 4'h1;
    if (slowTick) begin
      st_next.slowDiv = st_reg.slowDiv + 2'h1;
    end
    st_next.pready  = 1'b0;
    st_next.pslverr = 1'b0;
    // zero-wait answer: pready rises in the access cycle itself
    if (psel && !penable) begin
      st_next.pready  = 1'b1;
      st_next.pslverr = (hit == 2'h0);
      st_next.prdata  = 32'h0;
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (!pwrite && hit[i]) begin
          // upper bits zero, level in bit 4
          st_next.prdata[7:0] = {3'h0, chEvt[i].level,
                                 st_reg.cfg[i]};
        end
      end
    end
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (psel && penable && pwrite && st_reg.pready && hit[i]) begin
        st_next.cfg[i] = pwdata[EDGE_LSB+1:RATE_LSB];
      end
      if (!st_reg.gateSync2[i]) begin
        st_next.cfg[i] = CFG_RESET[EDGE_LSB+1:RATE_LSB];
      end
      st_next.irq[i] = chEvt[i].request;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------------
  generate
    for (genvar g = 0; g < NUM_CHAN; g++) begin : gCh
      always_comb begin
        if (st_reg.slowSync2) begin
          // slow modes ignore the rate field
          sampleEn[g] = slowTick && (st_reg.slowDiv == SLOW_DIV_MASK);
        end else begin
          sampleEn[g] =
            (st_reg.gearDiv & rate_mask(st_reg.cfg[g].rate)) == 4'h0;
        end
      end
      eif_channel uCh (
        .clock     (clock),
        .rst_n     (rst_n),
        .clockGate (st_reg.gateSync2[g]),
        .sampleEn  (sampleEn[g]),
        .cfg       (st_reg.cfg[g]),
        .pinIn     (pins[g]),
        .evt       (chEvt[g])
      );
    end
  endgenerate

  assign prdata     = st_reg.prdata;
  assign pready     = st_reg.pready;
  assign pslverr    = st_reg.pslverr;
  assign irqRequest = st_reg.irq;

endmodule : eif_top

// File: tb/eif_top_monitor.sv
// eif_top_monitor: port-level assertions for eif_top.
// assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module eif_top_monitor
  import eif_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [1:0]        ext_irq_clock_gate,
  input wire logic [1:0]        irqRequest
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire unmapped = paddr != EXT_IRQ2_CONFIG_ADDR
               && paddr != EXT_IRQ3_CONFIG_ADDR;
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_setup_answer: assert property (psel && !penable |=> pready)
    else $error("no answer in first access cycle");
  chk_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  chk_unmapped_error: assert property
    (psel && !penable && unmapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_high_bits_zero: assert property
    (pready && !pwrite |-> prdata[31:5] == 27'h0)
    else $error("unused bits read nonzero");
  chk_req_two_pulse: assert property (irqRequest[0] |=> !irqRequest[0])
    else $error("channel two request not a pulse");
  chk_req_three_pulse: assert property
    ($rose(irqRequest[1]) |=> !irqRequest[1])
    else $error("channel three request not a pulse");
  chk_gate_stops_req: assert property
    (!ext_irq_clock_gate[0] [*6] |-> !irqRequest[0])
    else $error("request while clock gate low");
  cover property (irqRequest[0]);
  cover property (irqRequest[1]);
  cover property (pready && pslverr);
endmodule : eif_top_monitor

bind eif_top eif_top_monitor i_mon (.clock, .rst_n, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .ext_irq_clock_gate,
  .irqRequest);

// File: tb/eif_pin_model.sv
// eif_pin_model: external pin sources and free-running low clock.
// assumes pin levels are requested on clock; low clock never stops.
`timescale 1ns/10ps
module eif_pin_model #(parameter int HALF = 10)
(
  input  wire logic       clock,
  input  wire logic [1:0] pinWant,
  output logic      [1:0] pinOut,
  output logic            lfTick
);
  int cnt = 0;
  initial begin
    pinOut = 2'h0;
    lfTick = 1'b0;
  end
  always @(posedge clock) begin
    pinOut <= pinWant;
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) lfTick <= ~lfTick;
  end
endmodule : eif_pin_model

// File: tb/ext_irq_edge_noise_filter_test.sv
// ext_irq_edge_noise_filter_test: directed bench for eif_top.
// assumes eif_top_monitor bound in; pins and low clock from pin model.
`timescale 1ns/10ps
module ext_irq_edge_noise_filter_test;
  import eif_pkg::*;
  logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic pready, pslverr, rerr, lfTick;
  logic [1:0] gate = 2'h3, want = 2'h0, pins, irqRequest;
  int bad_count = 0, tests_run = 0, nReq = 0, nReq3 = 0;
  initial forever #2.5 clock = ~clock;
  eif_pin_model i_pins (.clock, .pinWant(want), .pinOut(pins), .lfTick);
  eif_top i_dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .lowSpeedMode(slow),
    .lowFreqClockTick(lfTick), .ext_irq_clock_gate(gate),
    .ext_pin_channel_two(pins[0]), .ext_pin_channel_three(pins[1]),
    .irqRequest);
  always @(posedge clock) if (irqRequest[0] === 1'b1) nReq++;
  always @(posedge clock) if (irqRequest[1] === 1'b1) nReq3++;
  task automatic check(string name, logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic apb(logic wr, logic [ADDR_W-1:0] a, logic [31:0] d);
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    // no cycle count assumed: the wait ends when pready is seen; the watchdog bounds it
    do @(posedge clock); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic pin(logic v, int hold);
    @(negedge clock) begin
      nReq = 0;
      nReq3 = 0;
    end
    @(posedge clock) want <= {2{v}};
    repeat (hold) @(posedge clock);
  endtask : pin
  task automatic t_regs;
    apb(0, EXT_IRQ3_CONFIG_ADDR, 0); check("cfg3 reset", rdat, 0);
    apb(1, EXT_IRQ2_CONFIG_ADDR, 32'hFFFF_FFFF);
    apb(1, EXT_IRQ3_CONFIG_ADDR, 32'h5);
    apb(0, EXT_IRQ2_CONFIG_ADDR, 0); check("cfg2", rdat, 32'hF);
    apb(0, EXT_IRQ3_CONFIG_ADDR, 0); check("cfg3", rdat, 32'h5);
    apb(0, 14'h0010, 0); check("unmapped", rerr, 1);
  endtask : t_regs
  task automatic t_edges;
    for (int e = 0; e < 4; e++) begin
      apb(1, EXT_IRQ2_CONFIG_ADDR, 32'(e << 2)); // no enable modelled
      pin(1, 40); check("rise req", nReq, e == 0 || e == 2);
      if (e == 2) apb(0, EXT_IRQ2_CONFIG_ADDR, 0);
      if (e == 2) check("level high", rdat, 32'h18);
      pin(0, 40); check("fall req", nReq, e == 1 || e == 2);
      if (e == 2) apb(0, EXT_IRQ2_CONFIG_ADDR, 0);
      if (e == 2) check("level low", rdat, 32'h08);
    end
  endtask : t_edges
  task automatic t_rates;
    int lat, dv;
    for (int r = 0; r < 4; r++) begin
      dv = (r == 0) ? 1 : (2 << r);
      apb(1, EXT_IRQ2_CONFIG_ADDR, 32'(r));
      pin(1, 0);
      lat = 0;
      while (irqRequest[0] !== 1'b1 && lat < 200) @(posedge clock) lat++;
      check("rate latency", lat >= dv + 2 && lat <= 3 * dv + 8, 1);
      pin(0, 80);
    end
  endtask : t_rates
  task automatic t_noise;
    apb(1, EXT_IRQ2_CONFIG_ADDR, 32'hB);
    pin(1, 12); pin(0, 60); check("glitch", nReq, 0);
    pin(1, 80); check("wide rise", nReq, 1);
    pin(0, 80); check("wide fall", nReq, 1);
  endtask : t_noise
  task automatic t_slow;
    apb(1, EXT_IRQ2_CONFIG_ADDR, 32'h8);
    @(posedge clock) slow <= 1;
    repeat (260) @(posedge clock); // settle wait after mode change
    pin(1, 60); pin(0, 200); check("slow glitch", nReq, 0);
    pin(1, 400); check("slow accept", nReq, 1);
    pin(0, 400);
    @(posedge clock) slow <= 0;
    repeat (20) @(posedge clock);
  endtask : t_slow
  task automatic t_gate;
    @(posedge clock) gate <= 2'h2;
    repeat (8) @(posedge clock);
    apb(0, EXT_IRQ2_CONFIG_ADDR, 0); check("gated cfg", rdat, 0);
    pin(1, 40); pin(0, 40); check("gated req", nReq, 0);
    check("ch3 fall req", nReq3, 1);
    @(posedge clock) gate <= 2'h3;
  endtask : t_gate
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1;
    t_regs(); t_edges(); t_rates(); t_noise(); t_slow(); t_gate();
    stop_test();
  end
  initial begin
    #100000;
    bad_count++;
    stop_test();
  end
endmodule : ext_irq_edge_noise_filter_test
